// *** inc/psd_defines.vh ***
`ifndef PSD_DEFINES_VH
`define PSD_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSD_CTRL_OFS 8'h00
`define PSD_MADDR_OFS 8'h04
`define PSD_STAT_OFS 8'h08
`define PSD_DST_OFS 8'h10
`define PSD_SRC_OFS 8'h20
`define PSD_GIN_OFS 8'h30
`define PSD_RES_OFS 8'h40
`define PSD_GOUT_OFS 8'h50
// ----------------------------------------
// Control and status fields, reset values
// ----------------------------------------
`define PSD_OP_LSB 0
`define PSD_IMM_LSB 8
`define PSD_GRM_LSB 16
`define PSD_ACHK_BIT 18
`define PSD_MEM_BIT 19
`define PSD_GO_BIT 31
`define PSD_ZF_BIT 0
`define PSD_CF_BIT 1
`define PSD_PE_BIT 2
`define PSD_AF_BIT 3
`define PSD_IMM_GLOBAL_BIT 2
`define PSD_IMM_NOPE_BIT 3
`define PSD_CTRL_RST 32'h00000000
`define PSD_WORD_RST 32'h00000000
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define PSD_OP_MIN_SIGNED_DWORD 5'h00
`define PSD_OP_MAX_SIGNED_DWORD 5'h01
`define PSD_OP_MIN_UNSIGNED_DWORD 5'h02
`define PSD_OP_MAX_UNSIGNED_DWORD 5'h03
`define PSD_OP_MIN_SIGNED_BYTE 5'h04
`define PSD_OP_MAX_SIGNED_BYTE 5'h05
`define PSD_OP_MIN_UNSIGNED_WORD 5'h06
`define PSD_OP_MAX_UNSIGNED_WORD 5'h07
`define PSD_OP_ROUND_PACKED_SINGLE 5'h08
`define PSD_OP_ROUND_PACKED_DOUBLE 5'h09
`define PSD_OP_ROUND_SCALAR_SINGLE 5'h0a
`define PSD_OP_ROUND_SCALAR_DOUBLE 5'h0b
`define PSD_OP_EXTRACT_FLOAT_LANE 5'h0c
`define PSD_OP_INSERT_FLOAT_LANE 5'h0d
`define PSD_OP_INSERT_BYTE_LANE 5'h0e
`define PSD_OP_INSERT_DWORD_LANE 5'h0f
`define PSD_OP_INSERT_QWORD_LANE 5'h10
`define PSD_OP_EXTRACT_BYTE_LANE 5'h11
`define PSD_OP_EXTRACT_WORD_LANE 5'h12
`define PSD_OP_EXTRACT_DWORD_LANE 5'h13
`define PSD_OP_EXTRACT_QWORD_LANE 5'h14
`define PSD_OP_WIDEN 5'h15
`define PSD_OP_MULTI_SUM_ABS_DIFF 5'h16
`define PSD_OP_HORIZONTAL_MIN_SEARCH 5'h17
`define PSD_OP_PACKED_BIT_TEST 5'h18
`define PSD_OP_QWORD_EQUAL_COMPARE 5'h19
`define PSD_OP_PACK_DWORD_WORD_USAT 5'h1a
// ----------------------------------------
// Widening kinds (imm[2:0]), imm[3] selects zero extension
// ----------------------------------------
`define PSD_WK_BYTE_TO_WORD 3'h0
`define PSD_WK_BYTE_TO_DWORD 3'h1
`define PSD_WK_WORD_TO_DWORD 3'h2
`define PSD_WK_BYTE_TO_QWORD 3'h3
`define PSD_WK_WORD_TO_QWORD 3'h4
`define PSD_WK_DWORD_TO_QWORD 3'h5
// ----------------------------------------
// Rounding modes
// ----------------------------------------
`define PSD_RM_NEAREST 2'h0
`define PSD_RM_DOWN 2'h1
`define PSD_RM_UP 2'h2
`define PSD_RM_TRUNC 2'h3
`endif

// *** src/psd_datapath.v ***
// Summary of operation
// - Dword min/max, signed and unsigned variants
// - Signed byte and unsigned word min/max
// - Round single/double, scalar/packed to integral
// - Immediate picks one of four rounding modes
// - Immediate may select global rounding mode
// - Immediate bit suppresses inexact exception
// - Extract any float dword lane outward
// - Insert float lane, zero masked lanes
// - Insert byte, dword, qword into lane
// - Extract byte, word, dword, qword lane
// - Widen by sign or zero extension
// - Element counts and source widths per widening
// - Aligned widening memory access when checking on
// - Two bits pick source group; eight sums
// - Eleven destination bytes from 0 or 4
// - Sums over windows stepping one byte
// - Minimum word and index in low dword
// - Zero flag when AND is zero
// - Carry flag on inverted mask; destination kept
// - Qword lane equality compare
// - Pack signed dwords to words, unsigned saturation
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "psd_defines.vh"

module psd_datapath (
	input wire clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata
);

// ----------------------------------------
// State
// ----------------------------------------
reg [31:0] ctrl_q;
reg [3:0] maddr_q;
reg [127:0] dst_q;
reg [127:0] src_q;
reg [63:0] gin_q;
reg [127:0] res_q;
reg [63:0] gout_q;
reg zf_q, cf_q, pe_q, af_q;
reg wr_q;
reg [7:0] waddr_q;

// ----------------------------------------
// Float round to integral, value in low bits, inexact on top
// ----------------------------------------
function [64:0] fround;
	input [63:0] x;
	input dp;
	input [1:0] md;
	reg [63:0] b;
	reg [63:0] mm;
	reg [63:0] m;
	reg [63:0] t;
	reg [63:0] r;
	reg s, up, ix;
	integer e, fb;
	begin
		up = 1'b0;
		s = dp ? x[63] : x[31];
		b = dp ? {1'b0, x[62:0]} : {33'h000000000, x[30:0]};
		e = dp ? x[62:52] : x[30:23];
		e = e - (dp ? 1023 : 127);
		fb = dp ? 52 : 23;
		mm = (64'h0000000000000001 << fb) - 64'h0000000000000001;
		ix = 1'b0;
		r = b;
		if (e >= fb) begin
			// Already integral; a signalling NaN comes back quiet
			if (e == (dp ? 1024 : 128) && (b & mm) != 64'h0)
				r = b | (64'h0000000000000001 << (fb - 1));
		end else if (e < 0) begin
			// Magnitude below one: result is zero or one
			ix = (b != 64'h0);
			case (md)
				`PSD_RM_NEAREST: up = (e == -1) && ((b & mm) != 64'h0);
				`PSD_RM_DOWN: up = s;
				`PSD_RM_UP: up = !s;
				default: up = 1'b0;
			endcase
			r = (up && ix) ? (dp ? 64'h3ff0000000000000 : 64'h000000003f800000) : 64'h0;
		end else begin
			// Adding past the fraction carries into the exponent for free
			m = mm >> e;
			t = b & ~m;
			ix = ((b & m) != 64'h0);
			case (md)
				`PSD_RM_NEAREST: up = ((b & m) > ((m >> 1) + 64'h1)) ||
					(((b & m) == ((m >> 1) + 64'h1)) && ((t & (m + 64'h1)) != 64'h0));
				`PSD_RM_DOWN: up = s && ix;
				`PSD_RM_UP: up = !s && ix;
				default: up = 1'b0;
			endcase
			r = up ? (t + m + 64'h1) : t;
		end
		fround = dp ? {ix, s, r[62:0]} : {ix, 32'h00000000, s, r[30:0]};
	end
endfunction

// ----------------------------------------
// Register read decode
// ----------------------------------------
function [31:0] rdmux;
	input [7:0] a;
	begin
		rdmux = 32'h00000000;
		case ({a[7:4], 4'h0})
			`PSD_CTRL_OFS: begin
				if (a[3:2] == 2'h0)
					rdmux = ctrl_q;
				else if (a[3:2] == 2'h1)
					rdmux = {28'h0000000, maddr_q};
				else if (a[3:2] == 2'h2)
					rdmux = {28'h0000000, af_q, pe_q, cf_q, zf_q};
			end
			`PSD_DST_OFS: rdmux = dst_q[{a[3:2], 5'h00} +: 32];
			`PSD_SRC_OFS: rdmux = src_q[{a[3:2], 5'h00} +: 32];
			`PSD_GIN_OFS: if (!a[3]) rdmux = gin_q[{a[2], 5'h00} +: 32];
			`PSD_RES_OFS: rdmux = res_q[{a[3:2], 5'h00} +: 32];
			`PSD_GOUT_OFS: if (!a[3]) rdmux = gout_q[{a[2], 5'h00} +: 32];
			default: rdmux = 32'h00000000;
		endcase
	end
endfunction

// ----------------------------------------
// Execute decode: a control write with go runs in the same edge
// ----------------------------------------
wire ctrl_wr = wr_q && (waddr_q == `PSD_CTRL_OFS);
wire [31:0] ctrl_e = ctrl_wr ? hwdata : ctrl_q;
wire exec = ctrl_wr && hwdata[`PSD_GO_BIT];
wire [4:0] op = ctrl_e[`PSD_OP_LSB +: 5];
wire [7:0] imm = ctrl_e[`PSD_IMM_LSB +: 8];
wire mem_op = ctrl_e[`PSD_MEM_BIT];
wire [1:0] rmode = imm[`PSD_IMM_GLOBAL_BIT] ? ctrl_e[`PSD_GRM_LSB +: 2] : imm[1:0];

reg [127:0] res_n;
reg [63:0] gout_n;
reg zf_n, cf_n, pe_n;
reg fault, lt, sx;
reg [63:0] wsrc;
reg [3:0] amask;
reg [7:0] da, db;
reg [15:0] sum;
reg [15:0] mn;
reg [2:0] mi;
reg [64:0] fr;
reg [31:0] dw;
integer i, j;

// ----------------------------------------
// Datapath
// ----------------------------------------
always @* begin
	res_n = dst_q;
	gout_n = gout_q;
	zf_n = zf_q;
	cf_n = cf_q;
	pe_n = 1'b0;
	fault = 1'b0;
	lt = 1'b0;
	sx = !imm[3];
	wsrc = mem_op ? gin_q : src_q[63:0];
	amask = 4'h0;
	da = 8'h00;
	db = 8'h00;
	sum = 16'h0000;
	mn = 16'hffff;
	mi = 3'h0;
	fr = 65'h0;
	dw = 32'h00000000;
	case (op)
		`PSD_OP_MIN_SIGNED_DWORD, `PSD_OP_MAX_SIGNED_DWORD,
		`PSD_OP_MIN_UNSIGNED_DWORD, `PSD_OP_MAX_UNSIGNED_DWORD: begin
			for (i = 0; i < 4; i = i + 1) begin
				lt = op[1] ? (dst_q[32*i +: 32] < src_q[32*i +: 32]) :
					($signed(dst_q[32*i +: 32]) < $signed(src_q[32*i +: 32]));
				res_n[32*i +: 32] = (lt ^ op[0]) ? dst_q[32*i +: 32] : src_q[32*i +: 32];
			end
		end
		`PSD_OP_MIN_SIGNED_BYTE, `PSD_OP_MAX_SIGNED_BYTE: begin
			for (i = 0; i < 16; i = i + 1) begin
				lt = $signed(dst_q[8*i +: 8]) < $signed(src_q[8*i +: 8]);
				res_n[8*i +: 8] = (lt ^ op[0]) ? dst_q[8*i +: 8] : src_q[8*i +: 8];
			end
		end
		`PSD_OP_MIN_UNSIGNED_WORD, `PSD_OP_MAX_UNSIGNED_WORD: begin
			for (i = 0; i < 8; i = i + 1) begin
				lt = dst_q[16*i +: 16] < src_q[16*i +: 16];
				res_n[16*i +: 16] = (lt ^ op[0]) ? dst_q[16*i +: 16] : src_q[16*i +: 16];
			end
		end
		`PSD_OP_ROUND_PACKED_SINGLE, `PSD_OP_ROUND_SCALAR_SINGLE: begin
			// Scalar forms round lane 0 and keep the destination's upper lanes
			for (i = 0; i < 4; i = i + 1) begin
				if (i == 0 || op == `PSD_OP_ROUND_PACKED_SINGLE) begin
					fr = fround({32'h00000000, src_q[32*i +: 32]}, 1'b0, rmode);
					res_n[32*i +: 32] = fr[31:0];
					pe_n = pe_n | (fr[64] & !imm[`PSD_IMM_NOPE_BIT]);
				end
			end
		end
		`PSD_OP_ROUND_PACKED_DOUBLE, `PSD_OP_ROUND_SCALAR_DOUBLE: begin
			for (i = 0; i < 2; i = i + 1) begin
				if (i == 0 || op == `PSD_OP_ROUND_PACKED_DOUBLE) begin
					fr = fround(src_q[64*i +: 64], 1'b1, rmode);
					res_n[64*i +: 64] = fr[63:0];
					pe_n = pe_n | (fr[64] & !imm[`PSD_IMM_NOPE_BIT]);
				end
			end
		end
		`PSD_OP_EXTRACT_FLOAT_LANE:
			gout_n = {32'h00000000, dst_q[{imm[1:0], 5'h00} +: 32]};
		`PSD_OP_INSERT_FLOAT_LANE: begin
			// imm[7:6] source lane, imm[5:4] target lane, imm[3:0] zero mask
			dw = mem_op ? gin_q[31:0] : src_q[{imm[7:6], 5'h00} +: 32];
			res_n[{imm[5:4], 5'h00} +: 32] = dw;
			for (i = 0; i < 4; i = i + 1)
				if (imm[i])
					res_n[32*i +: 32] = 32'h00000000;
		end
		`PSD_OP_INSERT_BYTE_LANE: res_n[{imm[3:0], 3'h0} +: 8] = gin_q[7:0];
		`PSD_OP_INSERT_DWORD_LANE: res_n[{imm[1:0], 5'h00} +: 32] = gin_q[31:0];
		`PSD_OP_INSERT_QWORD_LANE: res_n[{imm[0], 6'h00} +: 64] = gin_q;
		`PSD_OP_EXTRACT_BYTE_LANE: gout_n = {56'h0, dst_q[{imm[3:0], 3'h0} +: 8]};
		`PSD_OP_EXTRACT_WORD_LANE: gout_n = {48'h0, dst_q[{imm[2:0], 4'h0} +: 16]};
		`PSD_OP_EXTRACT_DWORD_LANE: gout_n = {32'h0, dst_q[{imm[1:0], 5'h00} +: 32]};
		`PSD_OP_EXTRACT_QWORD_LANE: gout_n = dst_q[{imm[0], 6'h00} +: 64];
		`PSD_OP_WIDEN: begin
			// Alignment mask is the memory reference width less one
			case (imm[2:0])
				`PSD_WK_BYTE_TO_WORD: begin
					amask = 4'h7;
					for (i = 0; i < 8; i = i + 1)
						res_n[16*i +: 16] = {{8{sx & wsrc[8*i+7]}}, wsrc[8*i +: 8]};
				end
				`PSD_WK_BYTE_TO_DWORD: begin
					amask = 4'h3;
					for (i = 0; i < 4; i = i + 1)
						res_n[32*i +: 32] = {{24{sx & wsrc[8*i+7]}}, wsrc[8*i +: 8]};
				end
				`PSD_WK_WORD_TO_DWORD: begin
					amask = 4'h7;
					for (i = 0; i < 4; i = i + 1)
						res_n[32*i +: 32] = {{16{sx & wsrc[16*i+15]}}, wsrc[16*i +: 16]};
				end
				`PSD_WK_BYTE_TO_QWORD: begin
					amask = 4'h1;
					for (i = 0; i < 2; i = i + 1)
						res_n[64*i +: 64] = {{56{sx & wsrc[8*i+7]}}, wsrc[8*i +: 8]};
				end
				`PSD_WK_WORD_TO_QWORD: begin
					amask = 4'h3;
					for (i = 0; i < 2; i = i + 1)
						res_n[64*i +: 64] = {{48{sx & wsrc[16*i+15]}}, wsrc[16*i +: 16]};
				end
				default: begin
					amask = 4'h7;
					for (i = 0; i < 2; i = i + 1)
						res_n[64*i +: 64] = {{32{sx & wsrc[32*i+31]}}, wsrc[32*i +: 32]};
				end
			endcase
			fault = ctrl_e[`PSD_ACHK_BIT] && mem_op && ((maddr_q & amask) != 4'h0);
		end
		`PSD_OP_MULTI_SUM_ABS_DIFF: begin
			for (i = 0; i < 8; i = i + 1) begin
				sum = 16'h0000;
				for (j = 0; j < 4; j = j + 1) begin
					da = dst_q[8*(i+j) + (imm[2] ? 32 : 0) +: 8];
					db = src_q[{imm[1:0], 5'h00} + 8*j +: 8];
					sum = sum + {8'h00, (da > db) ? (da - db) : (db - da)};
				end
				res_n[16*i +: 16] = sum;
			end
		end
		`PSD_OP_HORIZONTAL_MIN_SEARCH: begin
			mn = src_q[15:0];
			mi = 3'h0;
			for (i = 1; i < 8; i = i + 1) begin
				// Strict compare keeps the lowest lane on a tie
				if (src_q[16*i +: 16] < mn) begin
					mn = src_q[16*i +: 16];
					mi = i[2:0];
				end
			end
			res_n = {109'h0, mi, mn};
		end
		`PSD_OP_PACKED_BIT_TEST: begin
			zf_n = ((dst_q & src_q) == 128'h0);
			cf_n = ((dst_q & ~src_q) == 128'h0);
		end
		`PSD_OP_QWORD_EQUAL_COMPARE: begin
			for (i = 0; i < 2; i = i + 1)
				res_n[64*i +: 64] = (dst_q[64*i +: 64] == src_q[64*i +: 64]) ?
					64'hffffffffffffffff : 64'h0;
		end
		`PSD_OP_PACK_DWORD_WORD_USAT: begin
			// Destination dwords fill the low four words, source the high four
			for (i = 0; i < 8; i = i + 1) begin
				dw = (i < 4) ? dst_q[32*i +: 32] : src_q[32*(i-4) +: 32];
				if (dw[31])
					res_n[16*i +: 16] = 16'h0000;
				else if (dw[30:16] != 15'h0)
					res_n[16*i +: 16] = 16'hffff;
				else
					res_n[16*i +: 16] = dw[15:0];
			end
		end
		default: res_n = dst_q;
	endcase
end

// ----------------------------------------
// AHB-Lite slave: zero wait states, OKAY only
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		hrdata <= `PSD_WORD_RST;
		wr_q <= 1'b0;
		waddr_q <= 8'h00;
	end else begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			waddr_q <= haddr[7:0];
			// Read data is fetched in the address phase so it stands in the data phase
			if (hsel && htrans[1] && !hwrite)
				hrdata <= rdmux(haddr[7:0]);
		end
	end
end

// ----------------------------------------
// Register writes and result capture
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		ctrl_q <= `PSD_CTRL_RST;
		maddr_q <= 4'h0;
		dst_q <= 128'h0;
		src_q <= 128'h0;
		gin_q <= 64'h0;
		res_q <= 128'h0;
		gout_q <= 64'h0;
		zf_q <= 1'b0;
		cf_q <= 1'b0;
		pe_q <= 1'b0;
		af_q <= 1'b0;
	end else begin
		if (wr_q) begin
			case ({waddr_q[7:4], 4'h0})
				`PSD_CTRL_OFS: begin
					if (waddr_q[3:2] == 2'h0)
						ctrl_q <= {1'b0, hwdata[30:0]};
					else if (waddr_q[3:2] == 2'h1)
						maddr_q <= hwdata[3:0];
				end
				`PSD_DST_OFS: dst_q[{waddr_q[3:2], 5'h00} +: 32] <= hwdata;
				`PSD_SRC_OFS: src_q[{waddr_q[3:2], 5'h00} +: 32] <= hwdata;
				`PSD_GIN_OFS: if (!waddr_q[3]) gin_q[{waddr_q[2], 5'h00} +: 32] <= hwdata;
				default: ;
			endcase
		end
		// A faulting access leaves results untouched, flags the fault and clears pe_q
		if (exec) begin
			af_q <= fault;
			pe_q <= pe_n;
			if (!fault) begin
				res_q <= res_n;
				gout_q <= gout_n;
				zf_q <= zf_n;
				cf_q <= cf_n;
			end
		end
	end
end

endmodule // psd_datapath
`default_nettype wire

// *** test/psd_datapath_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psd_defines.vh"
// ------
// Bus and result checks
// ------
module psd_mon (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	logic rd;
	logic wc_q;
	logic [7:0] a;
	logic [4:0] op_q;
	assign rd = hsel && htrans[1] && hready && !hwrite;
	assign a = haddr[7:0];
	// Last executed opcode; a CTRL write without go must not change it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wc_q <= 1'b0;
			op_q <= 5'h00;
		end else begin
			wc_q <= hsel && htrans[1] && hready && hwrite && a == `PSD_CTRL_OFS;
			if (wc_q && hwdata[31])
				op_q <= hwdata[4:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ready_high: assert property (hreadyout) else $error("ready low");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_held: assert property (!$past(rd) |-> $stable(hrdata)) else $error("read data moved");
	a_go_clear: assert property (rd && a == 8'h00 |=> !hrdata[31]) else $error("go reads one");
	a_unmapped_zero: assert property (rd && (a == 8'h0c || a == 8'h60) |=> hrdata == 0)
		else $error("unmapped read not zero");
	a_status_unused: assert property (rd && a == 8'h08 |=> hrdata[31:4] == 0)
		else $error("status spare bits set");
	a_hmin_clear: assert property (rd && op_q == `PSD_OP_HORIZONTAL_MIN_SEARCH && a[7:4] == 4'h4
		|=> (hrdata & ($past(a) == 8'h40 ? 32'hfff80000 : 32'hffffffff)) == 0)
		else $error("search spare bits set");
	a_extract_zext: assert property (rd && (op_q == 5'h0c || op_q == 5'h13) && a == 8'h54
		|=> hrdata == 0) else $error("extract not zero extended");
	c_hmin_read: cover property (rd && op_q == `PSD_OP_HORIZONTAL_MIN_SEARCH && a == 8'h40);
	c_extract_read: cover property (rd && op_q == `PSD_OP_EXTRACT_DWORD_LANE && a == 8'h50);
	c_status_read: cover property (rd && a == 8'h08 ##3 rd);
endmodule // psd_mon
bind psd_datapath psd_mon u_mon (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// *** test/psd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------
// Decode side: single word bus transfers
// ------
module psd_host (
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 0;
	end
	// Starts at a fresh edge, so an idle cycle always follows an execute
	task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule // psd_host
`default_nettype wire

// *** test/tb_packed_simd_integer_fp_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psd_defines.vh"
module tb_packed_simd_integer_fp_datapath;
	logic clk;
	logic rst_n;
	wire logic hsel, hwrite, hreadyout, hresp;
	wire logic [1:0] htrans;
	wire logic [2:0] hsize;
	wire logic [31:0] haddr, hwdata, hrdata;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] q;
	logic [127:0] dv, sv, rt [4];
	psd_datapath dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	psd_host u_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ------
	// Helpers
	// ------
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] x;
		u_host.xfer(1'b1, ad, d, x);
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] x);
		u_host.xfer(1'b0, ad, 32'h0, x);
	endtask
	task ldv(input logic [7:0] ad, input logic [127:0] v);
		for (int i = 0; i < 4; i++) wr(ad + 8'(4 * i), v[32 * i +: 32]);
	endtask
	task cv(input logic [7:0] ad, input logic [127:0] e);
		for (int i = 0; i < 4; i++) begin
			rd(ad + 8'(4 * i), q);
			chk(q, e[32 * i +: 32]);
		end
	endtask
	task stc(input logic [3:0] m, input logic [3:0] e);
		rd(`PSD_STAT_OFS, q);
		chk(q & {28'h0, m}, {28'h0, e});
	endtask
	task ex(input logic [4:0] op, input logic [7:0] im, input logic [31:0] x);
		wr(`PSD_CTRL_OFS, 32'h80000000 | x | {16'h0, im, 3'h0, op});
	endtask
	task tend(input string s);
		$display("test %s done", s);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Min or max per lane; odd opcodes take the larger
	function automatic logic [127:0] mm(input int op, input logic [127:0] a, b);
		logic [127:0] r = 0;
		int w = op < 4 ? 32 : op < 6 ? 8 : 16;
		bit sg = op < 2 || op == 4 || op == 5;
		logic [127:0] m = (128'h1 << w) - 1;
		longint x, y;
		for (int i = 0; i < 128 / w; i++) begin
			x = a >> i * w & m;
			y = b >> i * w & m;
			if (sg && x[w - 1]) x = x - (64'h1 << w);
			if (sg && y[w - 1]) y = y - (64'h1 << w);
			r |= (((x < y) != op[0] ? a : b) >> i * w & m) << i * w;
		end
		return r;
	endfunction
	// Widening by kind, sign or zero
	function automatic logic [127:0] wd(input int k, input bit z, input logic [63:0] s);
		logic [127:0] r = 0;
		int sw = (k == 0 || k == 1 || k == 3) ? 8 : (k == 2 || k == 4) ? 16 : 32;
		int dw = k == 0 ? 16 : k < 3 ? 32 : 64;
		longint v;
		for (int i = 0; i < 128 / dw; i++) begin
			v = s >> i * sw & ((64'h1 << sw) - 1);
			if (!z && v[sw - 1]) v = v - (64'h1 << sw);
			r |= (128'(v) & ((128'h1 << dw) - 1)) << i * dw;
		end
		return r;
	endfunction
	// Eight overlapping four byte sums
	function automatic logic [127:0] sad(input logic [127:0] d, s, input logic [2:0] im);
		logic [127:0] r = 0;
		int t, o;
		for (int j = 0; j < 8; j++) begin
			t = 0;
			for (int k = 0; k < 4; k++) begin
				o = d[(im[2] * 4 + j + k) * 8 +: 8] - s[(im[1:0] * 4 + k) * 8 +: 8];
				t += o < 0 ? -o : o;
			end
			r[16 * j +: 16] = 16'(t);
		end
		return r;
	endfunction
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		fail_count++;
		close_out;
	end
	// ------
	// Tests
	// ------
	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		cv(`PSD_RES_OFS, 0);
		rd(`PSD_CTRL_OFS, q);
		chk(q, 0);
		wr(8'h60, 32'hffffffff);
		rd(8'h60, q);
		chk(q, 0);
		tend("reset");
		dv = 128'h80000001_7fffffff_00ff80fe_12345678;
		sv = 128'h7fffffff_80000001_ff0001ff_12345679;
		ldv(`PSD_DST_OFS, dv);
		ldv(`PSD_SRC_OFS, sv);
		for (int i = 0; i < 8; i++) begin
			ex(5'(i), 0, 0);
			cv(`PSD_RES_OFS, mm(i, dv, sv));
		end
		for (int i = 0; i < 8; i++) begin
			ex(`PSD_OP_MULTI_SUM_ABS_DIFF, 8'(i), 0);
			cv(`PSD_RES_OFS, sad(dv, sv, 3'(i)));
		end
		tend("minmax sad");
		for (int i = 0; i < 3; i++) begin
			sv = i == 0 ? ~dv : i == 1 ? dv : 0;
			ldv(`PSD_SRC_OFS, sv);
			ex(`PSD_OP_PACKED_BIT_TEST, 0, 0);
			stc(4'h3, {2'h0, ~|(dv & ~sv), ~|(dv & sv)});
			cv(`PSD_RES_OFS, dv);
		end
		ldv(`PSD_SRC_OFS, {dv[127:32], ~dv[31:0]});
		ex(`PSD_OP_QWORD_EQUAL_COMPARE, 0, 0);
		cv(`PSD_RES_OFS, {64'hffffffffffffffff, 64'h0});
		tend("test compare");
		sv = 128'h3f800000_40200000_bfc00000_3fc00000;
		rt[0] = 128'h3f800000_40000000_c0000000_40000000;
		rt[1] = 128'h3f800000_40000000_c0000000_3f800000;
		rt[2] = 128'h3f800000_40400000_bf800000_40000000;
		rt[3] = 128'h3f800000_40000000_bf800000_3f800000;
		ldv(`PSD_SRC_OFS, sv);
		for (int m = 0; m < 4; m++) begin
			ex(`PSD_OP_ROUND_PACKED_SINGLE, 8'(m), 0);
			cv(`PSD_RES_OFS, rt[m]);
			stc(4'h4, 4'h4);
		end
		ex(`PSD_OP_ROUND_PACKED_SINGLE, 8'h0e, 32'h00010000);
		cv(`PSD_RES_OFS, rt[1]);
		stc(4'h4, 4'h0);
		ex(`PSD_OP_ROUND_SCALAR_SINGLE, 8'h02, 0);
		cv(`PSD_RES_OFS, {dv[127:32], 32'h40000000});
		tend("round");
		ex(`PSD_OP_EXTRACT_DWORD_LANE, 8'h02, 0);
		rd(`PSD_GOUT_OFS, q);
		chk(q, dv[95:64]);
		ex(`PSD_OP_EXTRACT_FLOAT_LANE, 8'h03, 0);
		rd(`PSD_GOUT_OFS, q);
		chk(q, dv[127:96]);
		rd(`PSD_GOUT_OFS + 8'h04, q);
		chk(q, 0);
		wr(`PSD_GIN_OFS, 32'h000000a5);
		ex(`PSD_OP_INSERT_BYTE_LANE, 8'h0f, 0);
		cv(`PSD_RES_OFS, {8'ha5, dv[119:0]});
		ex(`PSD_OP_INSERT_FLOAT_LANE, 8'h71, 0);
		cv(`PSD_RES_OFS, {sv[63:32], dv[95:32], 32'h0});
		tend("lanes");
		ex(`PSD_OP_EXTRACT_BYTE_LANE, 8'h0d, 0);
		rd(`PSD_GOUT_OFS, q);
		chk(q, {24'h0, dv[111:104]});
		ex(`PSD_OP_EXTRACT_WORD_LANE, 8'h05, 0);
		rd(`PSD_GOUT_OFS, q);
		chk(q, {16'h0, dv[95:80]});
		ex(`PSD_OP_EXTRACT_QWORD_LANE, 8'h01, 0);
		rd(`PSD_GOUT_OFS, q);
		chk(q, dv[95:64]);
		rd(`PSD_GOUT_OFS + 8'h04, q);
		chk(q, dv[127:96]);
		wr(`PSD_GIN_OFS + 8'h04, 32'h5a5a5a5a);
		ex(`PSD_OP_INSERT_QWORD_LANE, 8'h01, 0);
		cv(`PSD_RES_OFS, {32'h5a5a5a5a, 32'h000000a5, dv[63:0]});
		ex(`PSD_OP_INSERT_DWORD_LANE, 8'h01, 0);
		cv(`PSD_RES_OFS, {dv[127:64], 32'h000000a5, dv[31:0]});
		ex(`PSD_OP_INSERT_FLOAT_LANE, 8'h28, 32'h00080000);
		cv(`PSD_RES_OFS, {32'h0, 32'h000000a5, dv[63:0]});
		ldv(`PSD_SRC_OFS, 128'h40040000_00000000_bfe80000_00000000);
		ex(`PSD_OP_ROUND_PACKED_DOUBLE, 8'h00, 0);
		cv(`PSD_RES_OFS, 128'h40000000_00000000_bff00000_00000000);
		ex(`PSD_OP_ROUND_SCALAR_DOUBLE, 8'h02, 0);
		cv(`PSD_RES_OFS, {dv[127:64], 64'h8000000000000000});
		stc(4'h4, 4'h4);
		tend("more lanes");
		sv[63:0] = 64'h80017f02ff031004;
		ldv(`PSD_SRC_OFS, sv);
		for (int k = 0; k < 12; k++) begin
			ex(`PSD_OP_WIDEN, 8'(k % 6 + k / 6 * 8), 0);
			cv(`PSD_RES_OFS, wd(k % 6, k / 6, sv[63:0]));
		end
		wr(`PSD_GIN_OFS, 32'h00000005);
		wr(`PSD_GIN_OFS + 8'h04, 32'hfffffffe);
		wr(`PSD_MADDR_OFS, 32'h4);
		ex(`PSD_OP_WIDEN, 8'h05, 32'h000c0000);
		stc(4'h8, 4'h8);
		cv(`PSD_RES_OFS, wd(5, 1, sv[63:0]));
		wr(`PSD_MADDR_OFS, 32'h8);
		ex(`PSD_OP_WIDEN, 8'h05, 32'h000c0000);
		stc(4'h8, 4'h0);
		cv(`PSD_RES_OFS, wd(5, 0, 64'hfffffffe00000005));
		tend("widen");
		ldv(`PSD_DST_OFS, 128'h00001234_0000ffff_00010000_ffffffff);
		ldv(`PSD_SRC_OFS, 128'h00000001_00000000_7fffffff_80000000);
		ex(`PSD_OP_PACK_DWORD_WORD_USAT, 0, 0);
		cv(`PSD_RES_OFS, 128'h0001_0000_ffff_0000_1234_ffff_ffff_0000);
		ldv(`PSD_SRC_OFS, 128'h0009_0008_0003_0007_0005_0003_0004_0006);
		ex(`PSD_OP_HORIZONTAL_MIN_SEARCH, 0, 0);
		cv(`PSD_RES_OFS, 128'h0002_0003);
		tend("pack search");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		cv(`PSD_RES_OFS, 0);
		stc(4'hf, 4'h0);
		tend("mid reset");
		close_out;
	end
endmodule // tb_packed_simd_integer_fp_datapath
`default_nettype wire
